// ==== inc/rail_regs_pkg.sv ====
package rail_regs_pkg;

	// Register sub-addresses
	localparam logic [7:0]  ADDR_DDR_RAIL   = 8'h18;
	localparam logic [7:0]  ADDR_IO_RAIL    = 8'h19;

	// Field positions
	localparam int          SKIP_BIT        = 7;
	localparam int          RSVD_BIT        = 6;
	localparam int          CODE_W          = 6;

	// Reset values
	localparam logic [7:0]  DDR_RESET       = 8'h8c;
	localparam logic [7:0]  IO_RESET        = 8'hb2;
	localparam logic [7:0]  IO_STRAP_RESET  = 8'h9e;

	// Voltage code ladders, millivolts
	localparam logic [5:0]  DDR_KNEE        = 6'h1a;
	localparam logic [11:0] DDR_FINE_MV     = 12'h384;
	localparam logic [11:0] DDR_COARSE_MV   = 12'h640;
	localparam logic [5:0]  IO_KNEE         = 6'h0f;
	localparam logic [11:0] IO_FINE_MV      = 12'h497;
	localparam logic [11:0] IO_COARSE_MV    = 12'h640;
	localparam logic [11:0] FINE_STEP_MV    = 12'h019;
	localparam logic [11:0] COARSE_STEP_MV  = 12'h032;

	// Monitor blanking after an I/O rail write
	localparam int          CLK_HZ          = 10_000_000;
	localparam int          BLANK_TIME_MS   = 5;
	localparam int          BLANK_CYCLES    = BLANK_TIME_MS * (CLK_HZ / 1000);
	localparam int          BLANK_CNT_W     = 16;

	// Cycles the strap synchroniser needs after reset before it is trusted
	localparam logic [1:0]  STRAP_SETTLE    = 2'h2;

	typedef struct packed {
		logic               skip_en;
		logic               rsvd;
		logic [CODE_W-1:0]  code;
	} rail_reg_t;

	typedef struct packed {
		logic               wr;
		logic [7:0]         addr;
		logic [7:0]         wdata;
	} reg_req_t;

	typedef struct packed {
		rail_reg_t          ddr;
		rail_reg_t          io;
		logic [1:0]         strap_cnt;
		logic               strap_done;
		logic               strap_s1;
		logic               strap_s2;
		logic               ov_s1;
		logic               ov_s2;
		logic               uv_s1;
		logic               uv_s2;
		logic               ov;
		logic               uv;
		logic [7:0]         rd;
		logic [11:0]        ddr_mv;
		logic [11:0]        io_mv;
	} regs_state_t;

	typedef struct packed {
		logic                   active;
		logic [BLANK_CNT_W-1:0] cnt;
	} blank_state_t;

	// Two-slope code ladder: fine steps up to the knee, coarse steps above it
	function automatic logic [11:0] code_to_mv(
		input logic [5:0]  code,
		input logic [5:0]  knee,
		input logic [11:0] fine_base,
		input logic [11:0] coarse_base
	);
		logic [11:0] c;
		logic [11:0] k;
		c = {6'h00, code};
		k = {6'h00, knee};
		if (code <= knee) begin
			code_to_mv = 12'(fine_base + FINE_STEP_MV * c);
		end else begin
			code_to_mv = 12'(coarse_base + COARSE_STEP_MV * (c - k - 12'h001));
		end
	endfunction : code_to_mv

endpackage : rail_regs_pkg

// ==== core/monitor_blank_timer.sv ====
`timescale 1ns/100ps
module monitor_blank_timer #(
	parameter int BLANK_LEN = rail_regs_pkg::BLANK_CYCLES
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// Control
	input  wire logic start,
	output logic      active
);

	rail_regs_pkg::blank_state_t state_q;
	rail_regs_pkg::blank_state_t state_d;

	// A new start restarts the full window, so back-to-back writes extend it
	always_comb begin
		state_d = state_q;
		if (start) begin
			state_d.active = 1'b1;
			state_d.cnt    = rail_regs_pkg::BLANK_CNT_W'(BLANK_LEN - 1);
		end else if (state_q.active) begin
			if (state_q.cnt == '0) begin
				state_d.active = 1'b0;
			end else begin
				state_d.cnt = state_q.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign active = state_q.active;

endmodule : monitor_blank_timer

// ==== core/buck_rail_voltage_regs.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - DDR rail six-bit code, reset 0xC, two slopes
// - I/O rail register at 0x19, resets 0xB2
// - Rail writes accepted only while unlocked
// - I/O rail write blanks monitors for 5 ms
// - Bit 7 pulse-skip enable, reset one
// - I/O rail six-bit code, reset 0x32
// - Strap may select another I/O default
module buck_rail_voltage_regs #(
	parameter int BLANK_LEN = rail_regs_pkg::BLANK_CYCLES
) (
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	// Register access from the serial interface
	input  wire rail_regs_pkg::reg_req_t req,
	input  wire logic                    unlock_ok,
	output logic [7:0]                   rd_data,
	// Pins
	input  wire logic                    default_select_strap,
	input  wire logic                    ov_raw,
	input  wire logic                    uv_raw,
	// Rail controls
	output logic [5:0]                   ddr_buck_code,
	output logic                         ddr_skip_en,
	output logic [11:0]                  ddr_target_mv,
	output logic [5:0]                   io_buckboost_code,
	output logic                         light_load_skip_en,
	output logic [11:0]                  io_target_mv,
	// Monitor results
	output logic                         blanking,
	output logic                         ov_seen,
	output logic                         uv_seen
);

	rail_regs_pkg::regs_state_t state_q;
	rail_regs_pkg::regs_state_t state_d;
	logic                       wr_ddr;
	logic                       wr_io;
	logic                       blank_active;

	function automatic rail_regs_pkg::rail_reg_t to_rail(input logic [7:0] v);
		to_rail      = rail_regs_pkg::rail_reg_t'(v);
		to_rail.rsvd = 1'b0;
	endfunction : to_rail

	// Both ladders are decoded in logic, reset and checks, so keep one spelling of each
	function automatic logic [11:0] ddr_mv_of(input logic [5:0] code);
		ddr_mv_of = rail_regs_pkg::code_to_mv(code, rail_regs_pkg::DDR_KNEE, rail_regs_pkg::DDR_FINE_MV,
			rail_regs_pkg::DDR_COARSE_MV);
	endfunction : ddr_mv_of

	function automatic logic [11:0] io_mv_of(input logic [5:0] code);
		io_mv_of = rail_regs_pkg::code_to_mv(code, rail_regs_pkg::IO_KNEE, rail_regs_pkg::IO_FINE_MV,
			rail_regs_pkg::IO_COARSE_MV);
	endfunction : io_mv_of

	assign wr_ddr = req.wr && unlock_ok && req.addr == rail_regs_pkg::ADDR_DDR_RAIL;
	// A refused I/O write before the strap default lands must not open a blanking window either
	assign wr_io  = req.wr && unlock_ok && state_q.strap_done && req.addr == rail_regs_pkg::ADDR_IO_RAIL;

	monitor_blank_timer #(
		.BLANK_LEN (BLANK_LEN)
	) monitor_blank_timer_inst (
		.clk_sys (clk_sys),
		.rst     (rst),
		.start   (wr_io),
		.active  (blank_active)
	);

	always_comb begin
		state_d          = state_q;
		state_d.strap_s1 = default_select_strap;
		state_d.strap_s2 = state_q.strap_s1;
		state_d.ov_s1    = ov_raw;
		state_d.ov_s2    = state_q.ov_s1;
		state_d.uv_s1    = uv_raw;
		state_d.uv_s2    = state_q.uv_s1;
		// Strap is only trusted once the synchroniser has refilled after reset
		if (!state_q.strap_done) begin
			if (state_q.strap_cnt == rail_regs_pkg::STRAP_SETTLE) begin
				state_d.strap_done = 1'b1;
				if (state_q.strap_s2) begin
					state_d.io = to_rail(rail_regs_pkg::IO_STRAP_RESET);
				end
			end else begin
				state_d.strap_cnt = state_q.strap_cnt + 2'h1;
			end
		end else if (wr_io) begin
			state_d.io = to_rail(req.wdata);
		end
		if (wr_ddr) begin
			state_d.ddr = to_rail(req.wdata);
		end
		// I/O write in flight blanks too, so no glitch leaks in the write cycle
		state_d.ov = state_q.ov_s2 && !(blank_active || wr_io);
		state_d.uv = state_q.uv_s2 && !(blank_active || wr_io);
		case (req.addr)
			rail_regs_pkg::ADDR_DDR_RAIL: state_d.rd = state_q.ddr;
			rail_regs_pkg::ADDR_IO_RAIL:  state_d.rd = state_q.io;
			default:                      state_d.rd = 8'h00;
		endcase
		state_d.ddr_mv = ddr_mv_of(state_d.ddr.code);
		state_d.io_mv  = io_mv_of(state_d.io.code);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q        <= '0;
			state_q.ddr    <= rail_regs_pkg::rail_reg_t'(rail_regs_pkg::DDR_RESET);
			state_q.io     <= rail_regs_pkg::rail_reg_t'(rail_regs_pkg::IO_RESET);
			// Targets reset through the same ladders as the codes, so the pair never disagrees
			state_q.ddr_mv <= ddr_mv_of(rail_regs_pkg::DDR_RESET[5:0]);
			state_q.io_mv  <= io_mv_of(rail_regs_pkg::IO_RESET[5:0]);
		end else begin
			state_q <= state_d;
		end
	end

	assign rd_data            = state_q.rd;
	assign ddr_buck_code      = state_q.ddr.code;
	assign ddr_skip_en        = state_q.ddr.skip_en;
	assign ddr_target_mv      = state_q.ddr_mv;
	assign io_buckboost_code  = state_q.io.code;
	assign light_load_skip_en = state_q.io.skip_en;
	assign io_target_mv       = state_q.io_mv;
	assign blanking           = blank_active;
	assign ov_seen            = state_q.ov;
	assign uv_seen            = state_q.uv;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// Single-cycle events the properties below start from
	sequence io_write_acc;
		wr_io && state_q.strap_done;
	endsequence

	sequence ddr_write_acc;
		wr_ddr;
	endsequence

	sequence reset_release;
		$past(rst) && !rst;
	endsequence

	sequence strap_check;
		!state_q.strap_done && state_q.strap_cnt == rail_regs_pkg::STRAP_SETTLE;
	endsequence

	sequence monitor_open;
		!blank_active && !wr_io;
	endsequence

	// Eight cycles show the window holding without unrolling the whole 5 ms
	sequence blank_hold;
		blanking [*8];
	endsequence

	// Reset values and code ladders
	chk_ddr_reset_code: assert property (reset_release |-> ddr_buck_code == 6'h0c && ddr_target_mv == 12'h4b0)
		else $error("DDR code not at reset value");
	chk_ddr_mv_map: assert property (ddr_target_mv == ddr_mv_of(ddr_buck_code))
		else $error("DDR millivolt value does not match code");
	chk_io_mv_map: assert property (io_target_mv == io_mv_of(io_buckboost_code))
		else $error("I/O millivolt value does not match code");
	chk_io_reset_val: assert property (reset_release |-> {light_load_skip_en, io_buckboost_code} == 7'h72)
		else $error("I/O rail reset value wrong");

	// Write acceptance; the strap load may move the I/O register before it is done
	chk_locked_write: assert property (req.wr && !unlock_ok && state_q.strap_done |=>
		$stable(state_q.io) && $stable(state_q.ddr))
		else $error("Locked write changed a rail register");
	chk_unmapped_write: assert property (req.wr && state_q.strap_done
		&& req.addr != rail_regs_pkg::ADDR_DDR_RAIL && req.addr != rail_regs_pkg::ADDR_IO_RAIL
		|=> $stable(state_q.io) && $stable(state_q.ddr))
		else $error("Write to another address changed a rail register");
	chk_ddr_write: assert property (ddr_write_acc |=> ddr_skip_en == $past(req.wdata[7])
		&& ddr_buck_code == $past(req.wdata[5:0]))
		else $error("DDR rail register not written");
	chk_skip_write: assert property (io_write_acc |=> light_load_skip_en == $past(req.wdata[7]))
		else $error("Pulse-skip enable not written");
	chk_io_code_write: assert property (io_write_acc |=> io_buckboost_code == $past(req.wdata[5:0])
		&& io_target_mv == io_mv_of(io_buckboost_code))
		else $error("I/O rail code not written");

	// Read-back path, one cycle behind the address
	chk_rd_ddr: assert property (req.addr == rail_regs_pkg::ADDR_DDR_RAIL |=>
		rd_data == {$past(ddr_skip_en), 1'b0, $past(ddr_buck_code)})
		else $error("DDR rail read-back wrong");
	chk_rd_io: assert property (req.addr == rail_regs_pkg::ADDR_IO_RAIL |=>
		rd_data == {$past(light_load_skip_en), 1'b0, $past(io_buckboost_code)})
		else $error("I/O rail read-back wrong");
	chk_rd_unmapped: assert property (req.addr != rail_regs_pkg::ADDR_DDR_RAIL
		&& req.addr != rail_regs_pkg::ADDR_IO_RAIL |=> rd_data == 8'h00)
		else $error("Unmapped address read non-zero");
	chk_rsvd_zero: assert property (req.wr && req.wdata[6] |=> ##1 rd_data[6] == 1'b0)
		else $error("Reserved bit read as one");

	// Monitor blanking
	chk_blank_window: assert property (io_write_acc |=> blank_hold ##1 (!ov_seen && !uv_seen))
		else $error("Monitor not blanked after rail write");
	chk_blank_start: assert property (io_write_acc |=> blanking && !ov_seen && !uv_seen)
		else $error("Write cycle leaked a monitor result");
	chk_blank_mask: assert property (blanking |=> !ov_seen && !uv_seen)
		else $error("Monitor result leaked during blanking");
	chk_monitor_pass: assert property (monitor_open |=> ov_seen == $past(state_q.ov_s2)
		&& uv_seen == $past(state_q.uv_s2))
		else $error("Monitor result lost outside blanking");
	chk_ddr_no_blank: assert property (ddr_write_acc ##0 monitor_open |=> !blanking)
		else $error("DDR rail write opened a blanking window");

	// Strap default
	chk_strap_load: assert property (strap_check ##0 state_q.strap_s2
		|=> state_q.io == rail_regs_pkg::rail_reg_t'(rail_regs_pkg::IO_STRAP_RESET))
		else $error("Strap default not loaded");
	chk_strap_keep: assert property (!state_q.strap_done && !state_q.strap_s2 |=> $stable(state_q.io))
		else $error("I/O rail changed while waiting for the strap");
	chk_strap_done: assert property (strap_check |=> state_q.strap_done)
		else $error("Strap wait did not end");

endmodule : buck_rail_voltage_regs

// ==== dv/host_model.sv ====
`timescale 1ns/100ps
module host_model (
	// Clock
	input  wire logic                clk_sys,
	// Register access
	output rail_regs_pkg::reg_req_t  req,
	output logic                     unlock_ok,
	output logic                     rd_pending
);
	initial begin
		req = '0;
		unlock_ok = 1'b0;
		rd_pending = 1'b0;
	end
	// Unlock is granted for the write cycle only, so every write needs its own unlock
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u);
		@(posedge clk_sys);
		#1;
		req = '{wr: 1'b1, addr: a, wdata: d};
		unlock_ok = u;
		@(posedge clk_sys);
		#1;
		req.wr = 1'b0;
		unlock_ok = 1'b0;
	endtask : wr
	// Read data follows the address by one edge; the flag tells the watcher when to look
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		#1;
		req.addr = a;
		@(posedge clk_sys);
		#1;
		rd_pending = 1'b1;
		@(posedge clk_sys);
		#1;
		rd_pending = 1'b0;
	endtask : rd
endmodule : host_model

// ==== dv/buck_rail_voltage_regs_tb.sv ====
`timescale 1ns/100ps
module buck_rail_voltage_regs_tb;
	localparam int BLANK = 20;
	logic                    clk_sys, rst, strap, ov_raw, uv_raw, unlock_ok, rd_pending;
	rail_regs_pkg::reg_req_t req;
	logic [7:0]              rd_data, d;
	logic [5:0]              ddr_code, io_code;
	logic                    ddr_skip, io_skip, blanking, ov_seen, uv_seen;
	logic [11:0]             ddr_mv, io_mv;
	logic [5:0]              edges [6] = '{6'h1a, 6'h0f, 6'h1b, 6'h10, 6'h3f, 6'h23};
	logic [7:0]              exp_q [$];
	int                      mismatches, checks_done, n;

	host_model host_model_inst (.clk_sys(clk_sys), .req(req), .unlock_ok(unlock_ok), .rd_pending(rd_pending));
	buck_rail_voltage_regs #(.BLANK_LEN(BLANK)) buck_rail_voltage_regs_inst (.clk_sys(clk_sys), .rst(rst),
		.req(req), .unlock_ok(unlock_ok), .rd_data(rd_data), .default_select_strap(strap), .ov_raw(ov_raw),
		.uv_raw(uv_raw), .ddr_buck_code(ddr_code), .ddr_skip_en(ddr_skip), .ddr_target_mv(ddr_mv),
		.io_buckboost_code(io_code), .light_load_skip_en(io_skip), .io_target_mv(io_mv),
		.blanking(blanking), .ov_seen(ov_seen), .uv_seen(uv_seen));

	task automatic chk(input logic [18:0] got, input logic [18:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host_model_inst.rd(a);
	endtask : rd_exp
	task automatic do_reset(input logic s);
		rst = 1'b1;
		strap = s;
		repeat (20) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		repeat (5) @(posedge clk_sys);
	endtask : do_reset
	// Target in millivolts, worked out from the two code ladders
	function automatic logic [11:0] mv(input logic [5:0] c, input logic io);
		if (io) return (c <= 6'h0f) ? 12'h497 + 12'h019 * c : 12'h640 + 12'h032 * (c - 6'h10);
		return (c <= 6'h1a) ? 12'h384 + 12'h019 * c : 12'h640 + 12'h032 * (c - 6'h1b);
	endfunction : mv

	always @(negedge clk_sys) begin
		if (rd_pending === 1'b1) begin
			chk(19'(rd_data), 19'(exp_q.pop_front()), "read data");
		end
	end
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (100000) @(posedge clk_sys);
		mismatches++;
		wrap_up();
	end
	initial begin
		rst = 1'b1;
		strap = 1'b0;
		ov_raw = 1'b0;
		uv_raw = 1'b0;
		void'($urandom(32'hb5ce31ea));
		do_reset(1'b0);
		rd_exp(rail_regs_pkg::ADDR_DDR_RAIL, 8'h8c);
		rd_exp(rail_regs_pkg::ADDR_IO_RAIL, 8'hb2);
		chk({ddr_skip, ddr_code, ddr_mv}, {7'h4c, 12'h4b0}, "ddr reset");
		chk({io_skip, io_code, io_mv}, {7'h72, 12'hce4}, "io reset");
		$display("Test reset values done");
		host_model_inst.wr(rail_regs_pkg::ADDR_IO_RAIL, 8'h05, 1'b0);
		rd_exp(rail_regs_pkg::ADDR_IO_RAIL, 8'hb2);
		host_model_inst.wr(8'h1a, 8'hff, 1'b1);
		rd_exp(8'h1a, 8'h00);
		$display("Test locked and unmapped done");
		for (int i = 0; i < 12; i++) begin
			d = 8'($urandom);
			// I/O codes stay below the reserved range
			if (i < 6) d[5:0] = edges[i];
			else if (i[0]) d[5:0] = 6'($urandom_range(35));
			host_model_inst.wr(i[0] ? 8'h19 : 8'h18, d, 1'b1);
			if (i[0]) chk({io_skip, io_code, io_mv}, {d[7], d[5:0], mv(d[5:0], 1'b1)}, "io");
			else chk({ddr_skip, ddr_code, ddr_mv}, {d[7], d[5:0], mv(d[5:0], 1'b0)}, "ddr");
			rd_exp(i[0] ? 8'h19 : 8'h18, d & 8'hbf);
		end
		$display("Test code ladders done");
		ov_raw = 1'b1;
		uv_raw = 1'b1;
		host_model_inst.wr(rail_regs_pkg::ADDR_IO_RAIL, 8'h85, 1'b1);
		chk(19'(blanking), 19'h1, "blanking start");
		repeat (4) @(posedge clk_sys);
		#1;
		chk(19'({ov_seen, uv_seen}), 19'h0, "monitors blanked");
		n = 4;
		while (blanking === 1'b1 && n < BLANK + 10) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk(19'(n == BLANK), 19'h1, "blanking length");
		repeat (2) @(posedge clk_sys);
		#1;
		chk(19'({ov_seen, uv_seen}), 19'h3, "monitors after blanking");
		ov_raw = 1'b0;
		uv_raw = 1'b0;
		$display("Test blanking done");
		do_reset(1'b1);
		rd_exp(rail_regs_pkg::ADDR_IO_RAIL, 8'h9e);
		$display("Test strap default done");
		chk(19'(exp_q.size()), 19'h0, "queue drained");
		wrap_up();
	end
endmodule : buck_rail_voltage_regs_tb
